// ===== design/mcf_defines.svh
// offsets, field positions, reset values and widths of the fifo flag block
`ifndef MCF_DEFINES_SVH
`define MCF_DEFINES_SVH

// register port
`define MCF_ADDR_W            18
`define MCF_DATA_W            8
`define MCF_OFS_THRESH        18'h30b00
`define MCF_OFS_ERR_EN        18'h30b01
`define MCF_OFS_ERR_STS       18'h30b08
`define MCF_UNMAPPED_DATA     8'h00

// reset values
`define MCF_THRESH_RST        8'h00
`define MCF_ERR_EN_RST        8'h00
`define MCF_ERR_STS_RST       8'h00

// threshold register fields
`define MCF_WR_LEVEL_LSB      0
`define MCF_WR_LEVEL_MSB      3
`define MCF_RD_LEVEL_LSB      4
`define MCF_RD_LEVEL_MSB      7
`define MCF_LEVEL_W           4

// occupancy counters of the data fifos
`define MCF_COUNT_W           8

// error flag positions, same in enable and status registers
`define MCF_NUM_FLAGS         8
`define MCF_BIT_RD_DATA_UNDER 0
`define MCF_BIT_RD_INSTR_UNDER 1
`define MCF_BIT_WR_DATA_UNDER 2
`define MCF_BIT_WR_INSTR_UNDER 3
`define MCF_BIT_RD_DATA_OVER  4
`define MCF_BIT_RD_INSTR_OVER 5
`define MCF_BIT_WR_DATA_OVER  6
`define MCF_BIT_WR_INSTR_OVER 7

`endif

// ===== design/mcf_fifo_flags.sv
// fifo threshold flags, error status and shared error interrupt of the memory controller
//
// Operation
// R1 - write fifo nearly full when free slots are at or below the low threshold field
// R2 - read fifo nearly empty when filled slots are at or below the high field
// R3 - enable bit 0 gates read data underrun flag and its interrupt share
// R4 - enable bit 1 gates read instruction underrun flag and its interrupt share
// R5 - enable bit 2 gates write data underrun flag and its interrupt share
// R6 - enable bit 3 gates write instruction underrun flag and its interrupt share
// R7 - enable bit 4 gates read data overrun flag; that overrun should never occur
// R8 - enable bit 5 gates read instruction overrun flag and its interrupt share
// R9 - enable bit 6 gates write data overrun flag and its interrupt share
// R10 - enable bit 7 gates write instruction overrun flag and its interrupt share
// R11 - all eight underrun and overrun flags share one interrupt output
// R12 - read-only status register shows the eight flags in enable bit order
// R13 - interrupt high while any enabled flag is set, low otherwise
// R14 - both control registers reset to zero
`timescale 1ns/1ns
`include "mcf_defines.svh"
module mcf_fifo_flags
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   // register port
   input  wire mcf_pkg::mcf_addr_t reg_addr,
   input  wire mcf_pkg::mcf_byte_t reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output mcf_pkg::mcf_byte_t      reg_rdata,
   output logic                    reg_rvalid,
   // occupancy of the data fifos
   input  wire mcf_pkg::mcf_count_t wr_data_free_slots,
   input  wire mcf_pkg::mcf_count_t rd_data_filled_slots,
   // error event pulses from the four fifos
   input  wire logic               rd_data_under_evt,
   input  wire logic               rd_instr_under_evt,
   input  wire logic               wr_data_under_evt,
   input  wire logic               wr_instr_under_evt,
   input  wire logic               rd_data_over_evt,
   input  wire logic               rd_instr_over_evt,
   input  wire logic               wr_data_over_evt,
   input  wire logic               wr_instr_over_evt,
   // flag outputs
   output logic                    write_fifo_nearly_full,
   output logic                    read_fifo_nearly_empty,
   output logic                    fifo_error_irq
);
   // control and status storage
   mcf_pkg::mcf_byte_t  thresh_reg;
   mcf_pkg::mcf_byte_t  thresh_next;
   mcf_pkg::mcf_byte_t  err_en_reg;
   mcf_pkg::mcf_byte_t  err_en_next;
   mcf_pkg::mcf_byte_t  rdata_reg;
   mcf_pkg::mcf_byte_t  rdata_next;
   logic                rvalid_reg;
   logic                wfull_reg;
   logic                rempty_reg;
   logic                irq_reg;

   // decoded fields and names
   mcf_pkg::mcf_level_t write_fifo_full_level;
   mcf_pkg::mcf_level_t read_fifo_empty_level;
   mcf_pkg::mcf_byte_t  err_events;
   mcf_pkg::mcf_byte_t  err_flags;
   logic                rd_data_under_en;
   logic                rd_instr_under_en;
   logic                wr_data_under_en;
   logic                wr_instr_under_en;
   logic                rd_data_over_en;
   logic                rd_instr_over_en;
   logic                wr_data_over_en;
   logic                wr_instr_over_en;
   logic                rd_data_under_flag;
   logic                rd_instr_under_flag;
   logic                wr_data_under_flag;
   logic                wr_instr_under_flag;
   logic                rd_data_over_flag;
   logic                rd_instr_over_flag;
   logic                wr_data_over_flag;
   logic                wr_instr_over_flag;

   // address decode
   logic                hit_thresh;
   logic                hit_err_en;
   logic                hit_err_sts;
   logic                sts_clear;
   logic                wfull_next;
   logic                rempty_next;
   logic                irq_next;

   function automatic logic addr_is(input mcf_pkg::mcf_addr_t a,
                                    input mcf_pkg::mcf_addr_t ofs);
      addr_is = (a == ofs);
   endfunction

   assign hit_thresh  = addr_is(reg_addr, `MCF_OFS_THRESH);
   assign hit_err_en  = addr_is(reg_addr, `MCF_OFS_ERR_EN);
   assign hit_err_sts = addr_is(reg_addr, `MCF_OFS_ERR_STS);

   // writes to the status register or unmapped offsets are ignored
   assign thresh_next = (reg_wr && hit_thresh) ? reg_wdata : thresh_reg;
   assign err_en_next = (reg_wr && hit_err_en) ? reg_wdata : err_en_reg;

   // control registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         thresh_reg <= `MCF_THRESH_RST; // R14
         err_en_reg <= `MCF_ERR_EN_RST; // R14
      end
      else
      begin
         thresh_reg <= thresh_next;
         err_en_reg <= err_en_next;
      end
   end

   // threshold fields
   assign write_fifo_full_level = thresh_reg[`MCF_WR_LEVEL_MSB:`MCF_WR_LEVEL_LSB];
   assign read_fifo_empty_level = thresh_reg[`MCF_RD_LEVEL_MSB:`MCF_RD_LEVEL_LSB];

   // compare widened thresholds so counts above 15 never alias
   assign wfull_next  = (wr_data_free_slots <=
                         {{(`MCF_COUNT_W-`MCF_LEVEL_W){1'b0}}, write_fifo_full_level}); // R1
   assign rempty_next = (rd_data_filled_slots <=
                         {{(`MCF_COUNT_W-`MCF_LEVEL_W){1'b0}}, read_fifo_empty_level}); // R2

   // enable bits
   assign rd_data_under_en  = err_en_reg[`MCF_BIT_RD_DATA_UNDER];
   assign rd_instr_under_en = err_en_reg[`MCF_BIT_RD_INSTR_UNDER];
   assign wr_data_under_en  = err_en_reg[`MCF_BIT_WR_DATA_UNDER];
   assign wr_instr_under_en = err_en_reg[`MCF_BIT_WR_INSTR_UNDER];
   assign rd_data_over_en   = err_en_reg[`MCF_BIT_RD_DATA_OVER];
   assign rd_instr_over_en  = err_en_reg[`MCF_BIT_RD_INSTR_OVER];
   assign wr_data_over_en   = err_en_reg[`MCF_BIT_WR_DATA_OVER];
   assign wr_instr_over_en  = err_en_reg[`MCF_BIT_WR_INSTR_OVER];

   // event vector in status bit order
   assign err_events[`MCF_BIT_RD_DATA_UNDER]  = rd_data_under_evt;
   assign err_events[`MCF_BIT_RD_INSTR_UNDER] = rd_instr_under_evt;
   assign err_events[`MCF_BIT_WR_DATA_UNDER]  = wr_data_under_evt;
   assign err_events[`MCF_BIT_WR_INSTR_UNDER] = wr_instr_under_evt;
   // read data overrun is not expected in operation but is still reported
   assign err_events[`MCF_BIT_RD_DATA_OVER]   = rd_data_over_evt;
   assign err_events[`MCF_BIT_RD_INSTR_OVER]  = rd_instr_over_evt;
   assign err_events[`MCF_BIT_WR_DATA_OVER]   = wr_data_over_evt;
   assign err_events[`MCF_BIT_WR_INSTR_OVER]  = wr_instr_over_evt;

   // a status read clears the flags it returned
   assign sts_clear = reg_rd && hit_err_sts;

   genvar gi;
   generate
      for (gi = 0; gi < `MCF_NUM_FLAGS; gi++)
      begin : g_flag
         mcf_flag_cell u_cell
         (
            .clk      (clk),
            .rst_n    (rst_n),
            .event_in (err_events[gi]),
            .enable   (err_en_reg[gi]),   // R3 R4 R5 R6 R7 R8 R9 R10
            .clear    (sts_clear),
            .flag     (err_flags[gi])
         );
      end
   endgenerate

   assign rd_data_under_flag  = err_flags[`MCF_BIT_RD_DATA_UNDER];
   assign rd_instr_under_flag = err_flags[`MCF_BIT_RD_INSTR_UNDER];
   assign wr_data_under_flag  = err_flags[`MCF_BIT_WR_DATA_UNDER];
   assign wr_instr_under_flag = err_flags[`MCF_BIT_WR_INSTR_UNDER];
   assign rd_data_over_flag   = err_flags[`MCF_BIT_RD_DATA_OVER];
   assign rd_instr_over_flag  = err_flags[`MCF_BIT_RD_INSTR_OVER];
   assign wr_data_over_flag   = err_flags[`MCF_BIT_WR_DATA_OVER];
   assign wr_instr_over_flag  = err_flags[`MCF_BIT_WR_INSTR_OVER];

   // one shared line; the enable term also masks the flag itself
   assign irq_next = (rd_data_under_flag  & rd_data_under_en)  |
                     (rd_instr_under_flag & rd_instr_under_en) |
                     (wr_data_under_flag  & wr_data_under_en)  |
                     (wr_instr_under_flag & wr_instr_under_en) |
                     (rd_data_over_flag   & rd_data_over_en)   |
                     (rd_instr_over_flag  & rd_instr_over_en)  |
                     (wr_data_over_flag   & wr_data_over_en)   |
                     (wr_instr_over_flag  & wr_instr_over_en); // R11 R13

   // read mux; unmapped offsets return zero
   assign rdata_next = !reg_rd     ? rdata_reg :
                       hit_thresh  ? thresh_reg :
                       hit_err_en  ? err_en_reg :
                       hit_err_sts ? err_flags :   // R12
                       `MCF_UNMAPPED_DATA;

   // flag outputs are registered so the fifo logic sees glitch-free levels
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wfull_reg  <= 1'b0;
         rempty_reg <= 1'b0;
         irq_reg    <= 1'b0;
         rdata_reg  <= `MCF_ERR_STS_RST;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         wfull_reg  <= wfull_next;
         rempty_reg <= rempty_next;
         irq_reg    <= irq_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= reg_rd;
      end
   end

   assign write_fifo_nearly_full = wfull_reg;
   assign read_fifo_nearly_empty = rempty_reg;
   assign fifo_error_irq         = irq_reg;
   assign reg_rdata              = rdata_reg;
   assign reg_rvalid             = rvalid_reg;
endmodule

// ===== design/mcf_flag_cell.sv
// one enable-gated sticky error flag with clear on status read
`timescale 1ns/1ns
module mcf_flag_cell
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic event_in,
   input  wire logic enable,
   input  wire logic clear,
   output logic      flag
);
   logic flag_reg;
   logic flag_next;

   // a new event in the clearing cycle keeps the flag set; disabling drops it
   assign flag_next = enable & (event_in | (flag_reg & ~clear));

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         flag_reg <= 1'b0;
      else
         flag_reg <= flag_next;
   end

   assign flag = flag_reg;
endmodule

// ===== design/mcf_pkg.sv
// types shared by the fifo flag and interrupt block
package mcf_pkg;
   typedef logic [7:0]  mcf_byte_t;
   typedef logic [17:0] mcf_addr_t;
   typedef logic [3:0]  mcf_level_t;
   typedef logic [7:0]  mcf_count_t;
endpackage

// ===== verification/mcf_fabric_model.sv
// fabric side model: data fifo occupancy and fifo error event pulses
`timescale 1ns/1ns
module mcf_fabric_model
(
   input  wire logic        clk,
   output mcf_pkg::mcf_count_t free_slots,
   output mcf_pkg::mcf_count_t filled_slots,
   output mcf_pkg::mcf_byte_t  evt
);
   initial
   begin
      free_slots = 8'h20;
      filled_slots = 8'h20;
      evt = 8'h00;
   end
   // one-cycle event pulse; the fabric never holds an event level here
   task automatic pulse(input mcf_pkg::mcf_byte_t m);
      @(posedge clk) #1 evt = m;
      @(posedge clk) #1 evt = 8'h00;
   endtask
   task automatic levels(input mcf_pkg::mcf_count_t f, input mcf_pkg::mcf_count_t e);
      @(posedge clk) #1 free_slots = f;
      filled_slots = e;
   endtask
endmodule

// ===== verification/mcf_fifo_flags_props.sv
// assertions on the ports of the fifo flag and interrupt block
`timescale 1ns/1ns
`include "mcf_defines.svh"
module mcf_fifo_flags_props
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [17:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic [7:0]  wr_data_free_slots,
   input wire logic [7:0]  rd_data_filled_slots,
   input wire logic        rd_data_under_evt,
   input wire logic        rd_instr_under_evt,
   input wire logic        wr_data_under_evt,
   input wire logic        wr_instr_under_evt,
   input wire logic        rd_data_over_evt,
   input wire logic        rd_instr_over_evt,
   input wire logic        wr_data_over_evt,
   input wire logic        wr_instr_over_evt,
   input wire logic        write_fifo_nearly_full,
   input wire logic        read_fifo_nearly_empty,
   input wire logic        fifo_error_irq
);
   logic [7:0] thr_reg;
   logic [7:0] en_reg;
   logic [7:0] evt;
   logic       hit;
   assign evt = {wr_instr_over_evt, wr_data_over_evt, rd_instr_over_evt, rd_data_over_evt,
      wr_instr_under_evt, wr_data_under_evt, rd_instr_under_evt, rd_data_under_evt};
   assign hit = |(evt & en_reg);
   // shadow copies of the control registers, rebuilt from the write strobes
   always_ff @(posedge clk)
      if (!rst_n)
         thr_reg <= 8'h00;
      else if (reg_wr && reg_addr == `MCF_OFS_THRESH)
         thr_reg <= reg_wdata;
   always_ff @(posedge clk)
      if (!rst_n)
         en_reg <= 8'h00;
      else if (reg_wr && reg_addr == `MCF_OFS_ERR_EN)
         en_reg <= reg_wdata;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_full_level: assert property ($past(rst_n) |-> write_fifo_nearly_full ==
      ($past(wr_data_free_slots) <= {4'h0, $past(thr_reg[3:0])})) else $error("full level");
   a_empty_level: assert property ($past(rst_n) |-> read_fifo_nearly_empty ==
      ($past(rd_data_filled_slots) <= {4'h0, $past(thr_reg[7:4])})) else $error("empty level");
   a_irq_on_event: assert property (hit && !reg_wr |-> ##2 fifo_error_irq)
      else $error("irq missing after enabled event");
   a_irq_has_cause: assert property ($rose(fifo_error_irq) |-> $past(hit, 2))
      else $error("irq without enabled event");
   a_irq_all_off: assert property (en_reg == 8'h00 && $past(en_reg) == 8'h00 |-> !fifo_error_irq)
      else $error("irq with no enable set");
   a_rvalid_timing: assert property ($past(rst_n) |-> reg_rvalid == $past(reg_rd))
      else $error("read answer timing");
   a_read_enables: assert property (reg_rd && reg_addr == `MCF_OFS_ERR_EN |=>
      reg_rdata == $past(en_reg)) else $error("enable readback");
   // a flag drops one edge after its enable, so judge it by the enable seen at that edge
   a_status_gated: assert property (reg_rd && reg_addr == `MCF_OFS_ERR_STS |=>
      (reg_rdata & ~$past(en_reg, 2)) == 8'h00) else $error("disabled flag in status");
   cover property ($rose(fifo_error_irq));
   cover property ($rose(write_fifo_nearly_full));
   cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule
bind mcf_fifo_flags mcf_fifo_flags_props i_mcf_fifo_flags_props (.clk(clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .wr_data_free_slots(wr_data_free_slots),
   .rd_data_filled_slots(rd_data_filled_slots), .rd_data_under_evt(rd_data_under_evt),
   .rd_instr_under_evt(rd_instr_under_evt), .wr_data_under_evt(wr_data_under_evt),
   .wr_instr_under_evt(wr_instr_under_evt), .rd_data_over_evt(rd_data_over_evt),
   .rd_instr_over_evt(rd_instr_over_evt), .wr_data_over_evt(wr_data_over_evt),
   .wr_instr_over_evt(wr_instr_over_evt), .write_fifo_nearly_full(write_fifo_nearly_full),
   .read_fifo_nearly_empty(read_fifo_nearly_empty), .fifo_error_irq(fifo_error_irq));

// ===== verification/mcf_fifo_flags_tb_top.sv
// self-checking bench of the fifo flag and interrupt block
`timescale 1ns/1ns
`include "mcf_defines.svh"
module mcf_fifo_flags_tb_top;
   logic                clk = 1'b0;
   logic                rst_n = 1'b0;
   mcf_pkg::mcf_addr_t  reg_addr = 18'h00000;
   mcf_pkg::mcf_byte_t  reg_wdata = 8'h00;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   mcf_pkg::mcf_byte_t  reg_rdata;
   logic                reg_rvalid, full, empty, irq;
   mcf_pkg::mcf_count_t free_s, filled_s;
   mcf_pkg::mcf_byte_t  evt;
   int                  n_errors = 0;
   int                  cmp_count = 0;
   always #4 clk = ~clk;
   mcf_fabric_model i_mcf_fabric_model (.clk(clk), .free_slots(free_s), .filled_slots(filled_s),
      .evt(evt));
   mcf_fifo_flags i_mcf_fifo_flags (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .wr_data_free_slots(free_s), .rd_data_filled_slots(filled_s),
      .rd_data_under_evt(evt[0]), .rd_instr_under_evt(evt[1]), .wr_data_under_evt(evt[2]),
      .wr_instr_under_evt(evt[3]), .rd_data_over_evt(evt[4]), .rd_instr_over_evt(evt[5]),
      .wr_data_over_evt(evt[6]), .wr_instr_over_evt(evt[7]), .write_fifo_nearly_full(full),
      .read_fifo_nearly_empty(empty), .fifo_error_irq(irq));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input mcf_pkg::mcf_addr_t a, input mcf_pkg::mcf_byte_t d);
      @(posedge clk) #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk) #1 reg_wr = 1'b0;
   endtask
   // rvalid stands one cycle only, so the answer is judged right after the taking edge
   task automatic rd(input mcf_pkg::mcf_addr_t a, input mcf_pkg::mcf_byte_t e);
      @(posedge clk) #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk) #1 reg_rd = 1'b0;
      chk("rvalid", 8'h01, {7'h00, reg_rvalid});
      chk("rdata", e, reg_rdata);
   endtask
   task automatic t_regs();
      rd(`MCF_OFS_THRESH, 8'h00);
      rd(`MCF_OFS_ERR_EN, 8'h00);
      wr(`MCF_OFS_ERR_STS, 8'hff);
      rd(`MCF_OFS_ERR_STS, 8'h00);
      wr(18'h30b02, 8'h5a);
      rd(18'h30b02, 8'h00);
      wr(`MCF_OFS_THRESH, 8'ha4);
      rd(`MCF_OFS_THRESH, 8'ha4);
   endtask
   task automatic t_levels();
      i_mcf_fabric_model.levels(8'h04, 8'h0a);
      @(posedge clk) #1 chk("full", 8'h01, {7'h00, full});
      chk("empty", 8'h01, {7'h00, empty});
      i_mcf_fabric_model.levels(8'h05, 8'h0b);
      @(posedge clk) #1 chk("full", 8'h00, {7'h00, full});
      chk("empty", 8'h00, {7'h00, empty});
   endtask
   task automatic t_errors();
      wr(`MCF_OFS_ERR_EN, 8'hff);
      for (int i = 0; i < 8; i++)
      begin
         i_mcf_fabric_model.pulse(8'h01 << i);
         @(posedge clk) #1 chk("irq", 8'h01, {7'h00, irq});
         rd(`MCF_OFS_ERR_STS, 8'h01 << i);
         @(posedge clk) #1 chk("irq", 8'h00, {7'h00, irq});
      end
   endtask
   task automatic t_gating();
      wr(`MCF_OFS_ERR_EN, 8'h40);
      i_mcf_fabric_model.pulse(8'hff);
      rd(`MCF_OFS_ERR_STS, 8'h40);
      rd(`MCF_OFS_ERR_STS, 8'h00);
      i_mcf_fabric_model.pulse(8'h40);
      wr(`MCF_OFS_ERR_EN, 8'h00);
      @(posedge clk) #1 chk("irq", 8'h00, {7'h00, irq});
      rd(`MCF_OFS_ERR_STS, 8'h00);
   endtask
   // an event in the clearing cycle must survive the status read
   task automatic t_set_wins();
      wr(`MCF_OFS_ERR_EN, 8'h01);
      i_mcf_fabric_model.pulse(8'h01);
      fork
         i_mcf_fabric_model.pulse(8'h01);
         rd(`MCF_OFS_ERR_STS, 8'h01);
      join
      rd(`MCF_OFS_ERR_STS, 8'h01);
      rd(`MCF_OFS_ERR_STS, 8'h00);
   endtask
   task automatic test_done();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      t_regs();
      t_levels();
      t_errors();
      t_gating();
      t_set_wins();
      test_done();
   end
endmodule
